// File: ppm_pkg.sv
// Constants, field layout and carrier types of the per-port power management register bank.
// Assumes one core clock, an active-low fundamental reset and a synchronous hot reset pulse.
// Summary of operation
// - A sticky 3-bit auxiliary current field codes self powered up to 375 mA and comes out of reset at code 7.
// - The D1 and D2 support flags of the capability word always read zero.
// - A sticky 5-bit wake support field comes out of reset at 11001b, marking the states in which wakes are forwarded.
// - A 2-bit read-write power state field selects and reports D0 (code 0) or D3hot (code 3) and resets to 0.
// - A context preserved flag resets to one and says the port keeps its context when going from D3hot to D0.
// - Wake messages of the port are sent only while the sticky wake enable bit is set; it clears on full reset.
// - A hot reset leaves the wake enable bit unchanged; only the fundamental reset restores it.
// - The sticky wake status bit sets whenever the port itself raises a wake, enabled or not; writing one clears it.
// - A wake that is only forwarded through the bridge does not set the wake status bit.
// - The upstream port never originates a wake, so its wake status bit always reads zero.
// - Data select, data scale and data fields are read-only and read zero.
// - The bus state support and bus power/clock control enable bits read zero.
package ppm_pkg;

  // register byte addresses
  localparam logic [11:0] PPM_OFS_CAP = 12'h0C0;
  localparam logic [11:0] PPM_OFS_CSR = 12'h0C4;
  localparam logic [11:0] PPM_OFS_IRQ_STS = 12'h100;
  localparam logic [11:0] PPM_OFS_IRQ_MASK = 12'h104;

  // capability word fields
  localparam int PPM_CAP_AUX_LSB = 22;
  localparam int PPM_CAP_AUX_W = 3;
  localparam int PPM_CAP_D1_BIT = 25;
  localparam int PPM_CAP_D2_BIT = 26;
  localparam int PPM_CAP_SUP_LSB = 27;
  localparam int PPM_CAP_SUP_W = 5;

  // control/status word fields
  localparam int PPM_CSR_PS_LSB = 0;
  localparam int PPM_CSR_PS_W = 2;
  localparam int PPM_CSR_CTX_BIT = 3;
  localparam int PPM_CSR_WEN_BIT = 8;
  localparam int PPM_CSR_DATA_SEL_LSB = 9;
  localparam int PPM_CSR_DATA_SCALE_LSB = 13;
  localparam int PPM_CSR_WSTS_BIT = 15;
  localparam int PPM_CSR_BSS_BIT = 22;
  localparam int PPM_CSR_BPCC_BIT = 23;
  localparam int PPM_CSR_DATA_LSB = 24;

  // reset values and fixed values
  localparam logic [2:0] PPM_AUX_RST = 3'h7;
  localparam logic [4:0] PPM_SUP_RST = 5'h19;
  localparam logic [1:0] PPM_PS_D0 = 2'h0;
  localparam logic [1:0] PPM_PS_D3HOT = 2'h3;
  localparam logic PPM_CTX_RST = 1'h1;
  localparam logic PPM_WEN_RST = 1'h0;
  localparam logic PPM_WSTS_RST = 1'h0;
  localparam logic PPM_D1_SUP = 1'h0;
  localparam logic PPM_D2_SUP = 1'h0;
  localparam logic [3:0] PPM_DATA_SEL_VAL = 4'h0;
  localparam logic [1:0] PPM_DATA_SCALE_VAL = 2'h0;
  localparam logic [7:0] PPM_DATA_VAL = 8'h00;
  localparam logic PPM_BSS_VAL = 1'h0;
  localparam logic PPM_BPCC_VAL = 1'h0;

  // interrupt status/mask layout
  localparam int PPM_IRQ_W = 3;
  localparam int PPM_IRQ_OWN_WAKE = 0;
  localparam int PPM_IRQ_FWD_WAKE = 1;
  localparam int PPM_IRQ_PS_CHG = 2;
  localparam logic [2:0] PPM_IRQ_MASK_RST = 3'h0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } ppm_bus_req_t;

  typedef struct packed {
    logic own_wake;
    logic fwd_wake;
  } ppm_wake_evt_t;

  typedef enum logic [1:0] {
    PPM_ST_D0 = 2'b01,
    PPM_ST_D3HOT = 2'b10
  } ppm_pwr_st_t;

endpackage : ppm_pkg

// File: ppm_irq.sv
// Sticky event status with read-to-clear, a mask of the same layout and one level interrupt.
// Assumes the caller gives a one-cycle read pulse for the status register.
`timescale 1ns/1ps
`default_nettype none
module ppm_irq
  import ppm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // events
  input wire logic [ppm_pkg::PPM_IRQ_W-1:0] evt_set,
  // register access
  input wire logic sts_rd,
  input wire logic mask_wr,
  input wire logic [ppm_pkg::PPM_IRQ_W-1:0] mask_wdata,
  // state
  output logic [ppm_pkg::PPM_IRQ_W-1:0] sts,
  output logic [ppm_pkg::PPM_IRQ_W-1:0] mask,
  output logic irq
);
  typedef struct packed {
    logic [PPM_IRQ_W-1:0] sts;
    logic [PPM_IRQ_W-1:0] mask;
  } ppm_irq_st_t;

  ppm_irq_st_t st_reg;
  ppm_irq_st_t st_next;
  logic [PPM_IRQ_W-1:0] sts_nx;

  // set wins over the clear of a read in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < PPM_IRQ_W; gi++) begin : g_bit
      assign sts_nx[gi] = evt_set[gi] | (st_reg.sts[gi] & ~sts_rd);
    end
  endgenerate

  always_comb begin
    st_next = st_reg;
    st_next.sts = sts_nx;
    if (mask_wr) begin
      st_next.mask = mask_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '{sts: '0, mask: PPM_IRQ_MASK_RST};
    end else begin
      st_reg <= st_next;
    end
  end

  assign sts = st_reg.sts;
  assign mask = st_reg.mask;
  assign irq = |(st_reg.sts & st_reg.mask);
endmodule : ppm_irq
`default_nettype wire

// File: ppm_regs.sv
// Power management capability and control/status registers of one switch port.
// Assumes a single-cycle strobe register port, a fundamental reset on arst_n and a
// one-cycle hot reset pulse synchronous to clk. Event inputs are one-cycle pulses.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ppm_regs
  import ppm_pkg::*;
(
  // clock and resets
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hot_rst,
  // port role and lock control
  input wire logic is_upstream,
  input wire logic cfg_unlock,
  // register port
  input wire ppm_pkg::ppm_bus_req_t bus,
  output logic [31:0] rd_data,
  // wake events from the port logic
  input wire ppm_pkg::ppm_wake_evt_t wake_evt,
  // power management outputs
  output logic wake_msg_send,
  output logic [1:0] power_state_sel,
  output logic in_d3hot,
  output logic context_reset,
  output logic irq
);
  typedef struct packed {
    logic [2:0] aux_current_req;
    logic [4:0] wake_support;
    logic [1:0] power_state_sel;
    ppm_pwr_st_t pwr_st;
    logic context_preserved_flag;
    logic wake_msg_enable;
    logic wake_msg_status;
    logic [31:0] rd_data;
    logic wake_msg_send;
    logic context_reset;
  } ppm_st_t;

  ppm_st_t st_reg;
  ppm_st_t st_next;

  // decoded accesses
  logic wr_cap;
  logic wr_csr;
  logic wr_mask;
  logic rd_cap;
  logic rd_csr;
  logic rd_sts;
  logic rd_mask;
  logic own_wake;
  logic ps_change;
  logic [PPM_IRQ_W-1:0] irq_set;
  logic [PPM_IRQ_W-1:0] irq_sts;
  logic [PPM_IRQ_W-1:0] irq_mask;
  logic [31:0] cap_word;
  logic [31:0] csr_word;
  logic [1:0] ps_wr;
  logic ps_wr_ok;

  assign wr_cap = bus.wr && (bus.addr == PPM_OFS_CAP);
  assign wr_csr = bus.wr && (bus.addr == PPM_OFS_CSR);
  assign wr_mask = bus.wr && (bus.addr == PPM_OFS_IRQ_MASK);
  assign rd_cap = bus.rd && (bus.addr == PPM_OFS_CAP);
  assign rd_csr = bus.rd && (bus.addr == PPM_OFS_CSR);
  assign rd_sts = bus.rd && (bus.addr == PPM_OFS_IRQ_STS);
  assign rd_mask = bus.rd && (bus.addr == PPM_OFS_IRQ_MASK);

  // the upstream port never originates a wake, whatever the port logic claims
  assign own_wake = wake_evt.own_wake && !is_upstream;

  // only the two supported codes are accepted; D1/D2 writes keep the old state
  assign ps_wr = bus.wdata[PPM_CSR_PS_LSB +: PPM_CSR_PS_W];
  assign ps_wr_ok = (ps_wr == PPM_PS_D0) || (ps_wr == PPM_PS_D3HOT);
  assign ps_change = wr_csr && ps_wr_ok && (ps_wr != st_reg.power_state_sel) && !hot_rst;

  // read views; unlisted positions stay zero
  always_comb begin
    cap_word = 32'h0000_0000;
    cap_word[PPM_CAP_AUX_LSB +: PPM_CAP_AUX_W] = st_reg.aux_current_req;
    cap_word[PPM_CAP_D1_BIT] = PPM_D1_SUP;
    cap_word[PPM_CAP_D2_BIT] = PPM_D2_SUP;
    cap_word[PPM_CAP_SUP_LSB +: PPM_CAP_SUP_W] = st_reg.wake_support;
  end

  always_comb begin
    csr_word = 32'h0000_0000;
    csr_word[PPM_CSR_PS_LSB +: PPM_CSR_PS_W] = st_reg.power_state_sel;
    csr_word[PPM_CSR_CTX_BIT] = st_reg.context_preserved_flag;
    csr_word[PPM_CSR_WEN_BIT] = st_reg.wake_msg_enable;
    csr_word[PPM_CSR_DATA_SEL_LSB +: 4] = PPM_DATA_SEL_VAL;
    csr_word[PPM_CSR_DATA_SCALE_LSB +: 2] = PPM_DATA_SCALE_VAL;
    csr_word[PPM_CSR_WSTS_BIT] = st_reg.wake_msg_status && !is_upstream;
    csr_word[PPM_CSR_BSS_BIT] = PPM_BSS_VAL;
    csr_word[PPM_CSR_BPCC_BIT] = PPM_BPCC_VAL;
    csr_word[PPM_CSR_DATA_LSB +: 8] = PPM_DATA_VAL;
  end

  // interrupt events: own wake, forwarded wake, power state change
  always_comb begin
    irq_set = '0;
    irq_set[PPM_IRQ_OWN_WAKE] = own_wake;
    irq_set[PPM_IRQ_FWD_WAKE] = wake_evt.fwd_wake;
    irq_set[PPM_IRQ_PS_CHG] = ps_change;
  end

  ppm_irq u_irq (
    .clk(clk),
    .arst_n(arst_n),
    .evt_set(irq_set),
    .sts_rd(rd_sts),
    .mask_wr(wr_mask),
    .mask_wdata(bus.wdata[PPM_IRQ_W-1:0]),
    .sts(irq_sts),
    .mask(irq_mask),
    .irq(irq)
  );

  always_comb begin
    st_next = st_reg;
    st_next.wake_msg_send = 1'b0;
    st_next.context_reset = 1'b0;

    // sticky capability fields, written by software or the EEPROM loader
    if (wr_cap) begin
      st_next.aux_current_req = bus.wdata[PPM_CAP_AUX_LSB +: PPM_CAP_AUX_W];
      st_next.wake_support = bus.wdata[PPM_CAP_SUP_LSB +: PPM_CAP_SUP_W];
    end

    if (wr_csr) begin
      if (ps_wr_ok) begin
        st_next.power_state_sel = ps_wr;
      end
      // lockable: only takes a write while the init path holds the lock open
      if (cfg_unlock) begin
        st_next.context_preserved_flag = bus.wdata[PPM_CSR_CTX_BIT];
      end
      // the loader sets this during EEPROM load to arm wake from D3cold
      st_next.wake_msg_enable = bus.wdata[PPM_CSR_WEN_BIT];
    end

    // write one clears; a wake in the same cycle wins
    if (wr_csr && bus.wdata[PPM_CSR_WSTS_BIT]) begin
      st_next.wake_msg_status = 1'b0;
    end
    // forwarded wakes never reach this bit
    if (own_wake) begin
      st_next.wake_msg_status = 1'b1;
    end

    // wake message goes out only while enabled; status is set either way
    st_next.wake_msg_send = own_wake && st_reg.wake_msg_enable;

    // power state tracker
    case (st_reg.pwr_st)
      PPM_ST_D0: begin
        if (wr_csr && ps_wr == PPM_PS_D3HOT) begin
          st_next.pwr_st = PPM_ST_D3HOT;
        end
      end
      PPM_ST_D3HOT: begin
        if (wr_csr && ps_wr == PPM_PS_D0) begin
          st_next.pwr_st = PPM_ST_D0;
          // context is wiped on return only when the port does not keep it
          st_next.context_reset = !st_reg.context_preserved_flag;
        end
      end
      default: begin
        st_next.pwr_st = PPM_ST_D0;
      end
    endcase

    // hot reset restores the non-sticky fields only; sticky ones ride through
    if (hot_rst) begin
      st_next.power_state_sel = PPM_PS_D0;
      st_next.pwr_st = PPM_ST_D0;
      st_next.context_preserved_flag = PPM_CTX_RST;
      st_next.context_reset = 1'b0;
      st_next.wake_msg_enable = st_reg.wake_msg_enable;
    end

    // read data, one cycle after the strobe; unmapped reads return zero
    st_next.rd_data = 32'h0000_0000;
    if (rd_cap) begin
      st_next.rd_data = cap_word;
    end
    if (rd_csr) begin
      st_next.rd_data = csr_word;
    end
    if (rd_sts) begin
      st_next.rd_data = {{(32-PPM_IRQ_W){1'b0}}, irq_sts};
    end
    if (rd_mask) begin
      st_next.rd_data = {{(32-PPM_IRQ_W){1'b0}}, irq_mask};
    end
  end

  // sticky and non-sticky fields alike return to default on the fundamental reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg.aux_current_req <= PPM_AUX_RST;
      st_reg.wake_support <= PPM_SUP_RST;
      st_reg.power_state_sel <= PPM_PS_D0;
      st_reg.pwr_st <= PPM_ST_D0;
      st_reg.context_preserved_flag <= PPM_CTX_RST;
      st_reg.wake_msg_enable <= PPM_WEN_RST;
      st_reg.wake_msg_status <= PPM_WSTS_RST;
      st_reg.rd_data <= 32'h0000_0000;
      st_reg.wake_msg_send <= 1'b0;
      st_reg.context_reset <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data = st_reg.rd_data;
  assign wake_msg_send = st_reg.wake_msg_send;
  assign power_state_sel = st_reg.power_state_sel;
  assign in_d3hot = (st_reg.pwr_st == PPM_ST_D3HOT);
  assign context_reset = st_reg.context_reset;
endmodule : ppm_regs
`default_nettype wire

// File: ppm_host.sv
// Host configuration master model for the power management registers.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module ppm_host (
  // clock
  input wire logic clk,
  // register port
  output var ppm_pkg::ppm_bus_req_t bus,
  input wire logic [31:0] rd_data
);
  import ppm_pkg::*;
  initial bus = '0;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    bus <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    // released lines inverted so stale values never look valid
    bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    #1;
    q = rd_data;
  endtask : xfer
  // the loader sets the wake enable through this same write
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask : rd
endmodule : ppm_host
`default_nettype wire

// File: ppm_regs_asserts.sv
// Port-level checks of ppm_regs.
// Assumes it is bound to ppm_regs; one clock, reset arst_n.
`timescale 1ns/1ps
`default_nettype none
module ppm_regs_asserts (
  // clock and resets
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hot_rst,
  // control
  input wire logic is_upstream,
  input wire logic cfg_unlock,
  // register port and events
  input wire ppm_pkg::ppm_bus_req_t bus,
  input wire logic [31:0] rd_data,
  input wire ppm_pkg::ppm_wake_evt_t wake_evt,
  // outputs
  input wire logic wake_msg_send,
  input wire logic [1:0] power_state_sel,
  input wire logic in_d3hot,
  input wire logic context_reset,
  input wire logic irq
);
  import ppm_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_rd_cap;
    bus.rd && bus.addr == PPM_OFS_CAP;
  endsequence
  sequence s_rd_csr;
    bus.rd && bus.addr == PPM_OFS_CSR;
  endsequence
  a_cap_fixed_zero:
    assert property (s_rd_cap |=> rd_data[26:25] == 2'h0 && rd_data[21:0] == 22'h0)
    else $error("capability fixed bits not zero");
  a_csr_ro_zero:
    assert property (s_rd_csr |=> rd_data[31:16] == 16'h0 && rd_data[14:9] == 6'h0 && rd_data[7:4] == 4'h0
      && rd_data[2] == 1'h0)
    else $error("control read-only bits not zero");
  a_upstream_no_status:
    assert property (s_rd_csr ##0 is_upstream |=> rd_data[15] == 1'h0)
    else $error("upstream wake status set");
  a_read_idle_zero:
    assert property (!bus.rd |=> rd_data == 32'h0)
    else $error("read data outside read cycle");
  a_wake_msg_cause:
    assert property (wake_msg_send |-> $past(wake_evt.own_wake) && !$past(is_upstream))
    else $error("wake message without own wake");
  a_power_state_legal:
    assert property (power_state_sel == PPM_PS_D0 || power_state_sel == PPM_PS_D3HOT)
    else $error("reserved power state");
  a_d3hot_match:
    assert property (in_d3hot == (power_state_sel == PPM_PS_D3HOT))
    else $error("d3hot level mismatch");
  a_hot_rst_d0:
    assert property (hot_rst |=> power_state_sel == PPM_PS_D0 && !context_reset)
    else $error("hot reset did not return to d0");
  a_ctx_reset_cause:
    assert property (context_reset |-> $past(bus.wr) && $past(in_d3hot) && !in_d3hot ##1 !context_reset)
    else $error("context reset without d3hot exit");
endmodule : ppm_regs_asserts
`default_nettype wire

// File: ppm_regs_tb.sv
// Self-checking bench of ppm_regs: register bank, wake events, resets, interrupt.
// Assumes ppm_host drives the register port.
`timescale 1ns/1ps
`default_nettype none
module ppm_regs_tb;
  import ppm_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hot_rst = 1'b0;
  logic is_upstream = 1'b0;
  logic cfg_unlock = 1'b0;
  ppm_wake_evt_t wake_evt = '0;
  ppm_bus_req_t bus;
  logic [31:0] rd_data;
  logic wake_msg_send;
  logic [1:0] power_state_sel;
  logic in_d3hot;
  logic context_reset;
  logic irq;
  int mismatches = 0;
  int total_checks = 0;
  always #25 clk = ~clk;
  ppm_host host (.clk(clk), .bus(bus), .rd_data(rd_data));
  ppm_regs uut (.clk(clk), .arst_n(arst_n), .hot_rst(hot_rst), .is_upstream(is_upstream),
    .cfg_unlock(cfg_unlock), .bus(bus), .rd_data(rd_data), .wake_evt(wake_evt), .wake_msg_send(wake_msg_send),
    .power_state_sel(power_state_sel), .in_d3hot(in_d3hot), .context_reset(context_reset), .irq(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    host.rd(a, d);
    chk(d, exp, $sformatf("register %h", a));
  endtask : rchk
  // bits are hot reset, own wake, forwarded wake
  task automatic pulse(input logic [2:0] v);
    @(posedge clk);
    {hot_rst, wake_evt} <= v;
    @(posedge clk);
    {hot_rst, wake_evt} <= 3'h0;
    #1;
  endtask : pulse
  task automatic t_cap;
    rchk(PPM_OFS_CAP, 32'hC9C00000);
    rchk(PPM_OFS_CSR, 32'h00000008);
    host.wr(12'h0C8, 32'hFFFFFFFF);
    rchk(12'h0C8, 32'h00000000);
    host.wr(PPM_OFS_CAP, 32'hFFFFFFFF);
    rchk(PPM_OFS_CAP, 32'hF9C00000);
    for (int i = 7; i >= 0; i--) begin
      host.wr(PPM_OFS_CAP, {PPM_SUP_RST, 2'h3, i[2:0], 22'h3FFFFF});
      rchk(PPM_OFS_CAP, {PPM_SUP_RST, 2'h0, i[2:0], 22'h000000});
    end
  endtask : t_cap
  task automatic t_csr;
    host.wr(PPM_OFS_CSR, 32'hFFFFFFFF);
    rchk(PPM_OFS_CSR, 32'h0000010B);
    chk({30'h0, power_state_sel}, {30'h0, PPM_PS_D3HOT}, "power state");
    chk({31'h0, in_d3hot}, 32'h00000001, "in d3hot");
    host.wr(PPM_OFS_CSR, 32'h00000101);
    rchk(PPM_OFS_CSR, 32'h0000010B);
    host.wr(PPM_OFS_CSR, 32'h00000102);
    rchk(PPM_OFS_CSR, 32'h0000010B);
    // flag still one: leaving d3hot keeps the context
    host.wr(PPM_OFS_CSR, 32'h00000100);
    chk({31'h0, context_reset}, 32'h00000000, "context reset");
    chk({31'h0, in_d3hot}, 32'h00000000, "in d3hot");
    @(posedge clk) cfg_unlock <= 1'b1;
    host.wr(PPM_OFS_CSR, 32'h00000103);
    rchk(PPM_OFS_CSR, 32'h00000103);
    host.wr(PPM_OFS_CSR, 32'h00000100);
    chk({31'h0, context_reset}, 32'h00000001, "context reset");
    chk({31'h0, in_d3hot}, 32'h00000000, "in d3hot");
    @(posedge clk);
    #1;
    chk({31'h0, context_reset}, 32'h00000000, "context reset");
  endtask : t_csr
  task automatic t_wake;
    host.wr(PPM_OFS_IRQ_MASK, 32'h00000007);
    rchk(PPM_OFS_IRQ_MASK, 32'h00000007);
    rchk(PPM_OFS_IRQ_STS, 32'h00000004);
    pulse(3'h2);
    chk({31'h0, wake_msg_send}, 32'h00000001, "wake message");
    chk({31'h0, irq}, 32'h00000001, "irq");
    @(posedge clk);
    #1;
    chk({31'h0, wake_msg_send}, 32'h00000000, "wake message");
    rchk(PPM_OFS_CSR, 32'h00008100);
    rchk(PPM_OFS_IRQ_STS, 32'h00000001);
    chk({31'h0, irq}, 32'h00000000, "irq");
    host.wr(PPM_OFS_CSR, 32'h00008000);
    rchk(PPM_OFS_CSR, 32'h00000000);
    host.wr(PPM_OFS_IRQ_MASK, 32'h00000001);
    pulse(3'h1);
    chk({31'h0, irq}, 32'h00000000, "irq");
    rchk(PPM_OFS_CSR, 32'h00000000);
    rchk(PPM_OFS_IRQ_STS, 32'h00000002);
    pulse(3'h2);
    chk({31'h0, wake_msg_send}, 32'h00000000, "wake message");
    rchk(PPM_OFS_CSR, 32'h00008000);
    rchk(PPM_OFS_IRQ_STS, 32'h00000001);
    // enable on, status left set so the upstream view must hide it
    host.wr(PPM_OFS_CSR, 32'h00000100);
    @(posedge clk) is_upstream <= 1'b1;
    pulse(3'h2);
    chk({31'h0, wake_msg_send}, 32'h00000000, "wake message");
    rchk(PPM_OFS_CSR, 32'h00000100);
    rchk(PPM_OFS_IRQ_STS, 32'h00000000);
    @(posedge clk) is_upstream <= 1'b0;
    rchk(PPM_OFS_CSR, 32'h00008100);
  endtask : t_wake
  task automatic t_resets;
    host.wr(PPM_OFS_CSR, 32'h00000103);
    pulse(3'h4);
    chk({30'h0, power_state_sel}, {30'h0, PPM_PS_D0}, "power state");
    chk({31'h0, in_d3hot}, 32'h00000000, "in d3hot");
    rchk(PPM_OFS_CSR, 32'h00008108);
    rchk(PPM_OFS_CAP, 32'hC8000000);
    @(posedge clk) arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rchk(PPM_OFS_CSR, 32'h00000008);
    rchk(PPM_OFS_CAP, 32'hC9C00000);
    // loader arms wake from d3cold right after the fundamental reset
    host.wr(PPM_OFS_CSR, 32'h00000108);
    rchk(PPM_OFS_CSR, 32'h00000108);
  endtask : t_resets
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    t_cap();
    t_csr();
    t_wake();
    t_resets();
    tally_and_finish();
  end
  // tests need about 150 cycles
  initial begin
    repeat (2000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
endmodule : ppm_regs_tb
bind ppm_regs ppm_regs_asserts chk_i (.clk(clk), .arst_n(arst_n), .hot_rst(hot_rst), .is_upstream(is_upstream),
  .cfg_unlock(cfg_unlock), .bus(bus), .rd_data(rd_data), .wake_evt(wake_evt), .wake_msg_send(wake_msg_send),
  .power_state_sel(power_state_sel), .in_d3hot(in_d3hot), .context_reset(context_reset), .irq(irq));
`default_nettype wire
